// ==== pld_output_macrocell.sv ====
module pld_output_macrocell
    import pld_pkg::*;
(
    // Clock and reset
    input  wire logic                           clock,
    input  wire logic                           rstn,
    // Dedicated inputs and shared enable pin
    input  wire logic [pld_pkg::N_DED-1:0]      ded_in,
    input  wire logic                           oe_pin_n,
    // Cell pins, split in three
    input  wire logic [pld_pkg::N_CELL-1:0]     io_in,
    output logic      [pld_pkg::N_CELL-1:0]     io_out,
    output logic      [pld_pkg::N_CELL-1:0]     io_oe,
    // Pattern programming and readback
    input  wire logic                           prog_we,
    input  wire logic [pld_pkg::ADDR_W-1:0]     prog_addr,
    input  wire logic [pld_pkg::COL_W-1:0]      prog_wdata,
    input  wire logic                           rd_en,
    input  wire logic [pld_pkg::ADDR_W-1:0]     rd_addr,
    output logic      [pld_pkg::COL_W-1:0]      rd_data,
    // Cell configuration
    input  wire logic                           cfg_we,
    input  wire logic [pld_pkg::CELL_W-1:0]     cfg_cell,
    input  wire logic [2:0]                     cfg_wdata,
    // Security and preload
    input  wire logic                           secure_set,
    output logic                                secure,
    input  wire logic                           preload_en,
    input  wire logic [pld_pkg::N_CELL-1:0]     preload_data
);

    logic [N_TERM-1:0][COL_W-1:0] fuse;
    logic [N_CELL-1:0][2:0]       cfg;
    logic [N_CELL-1:0][2:0]       next_cfg;
    logic                         next_secure;
    logic [N_CELL-1:0]            reg_q;
    logic [N_CELL-1:0]            pin_mask;
    logic [N_SIG-1:0]             sig;
    logic [COL_W-1:0]             lit;
    logic [N_TERM-1:0]            term;

    // ============================================================
    // Pattern store
    pld_fuse_store u_store (
        .clock    (clock),
        .rstn     (rstn),
        .wr_en    (prog_we),
        .wr_addr  (prog_addr),
        .wr_data  (prog_wdata),
        .rd_en    (rd_en),
        .rd_addr  (rd_addr),
        .rd_blank (secure),
        .rd_data  (rd_data),
        .fuse     (fuse)
    );

    // ============================================================
    // Configuration and security state
    always_comb
    begin
        next_cfg    = cfg;
        next_secure = secure | secure_set;
        if (cfg_we && (int'(cfg_cell) < N_CELL))
        begin
            next_cfg[cfg_cell] = cfg_wdata;
        end
    end

    // Unprogrammed cells come up registered and active low
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg    <= {N_CELL{CFG_RESET}};
            secure <= 1'b0;
        end
        else
        begin
            cfg    <= next_cfg;
            secure <= next_secure;
        end
    end

    // ============================================================
    // Array signals and literal columns
    // A registered cell never feeds its pin back into the array
    genvar p;
    generate
        for (p = 0; p < N_CELL; p++)
        begin : g_pin
            assign pin_mask[p] = io_in[p] & cfg[p][STORE_BIT];
        end
    endgenerate

    assign sig = {pin_mask, reg_q, ded_in};

    // True and complement column of every array signal
    genvar s;
    generate
        for (s = 0; s < N_SIG; s++)
        begin : g_lit
            assign lit[2*s]   = sig[s];
            assign lit[2*s+1] = ~sig[s];
        end
    endgenerate

    // Product terms; an intact pair of fuses holds the term low
    genvar t;
    generate
        for (t = 0; t < N_TERM; t++)
        begin : g_term
            assign term[t] = &(~fuse[t] | lit);
        end
    endgenerate

    // ============================================================
    // Output cells
    genvar c;
    generate
        for (c = 0; c < N_CELL; c++)
        begin : g_cell
            pld_cell u_cell (
                .clock       (clock),
                .rstn        (rstn),
                .sum_terms   (term[c*TERMS_CELL +: SUM_TERMS]),
                .oe_term     (term[c*TERMS_CELL + SUM_TERMS]),
                .cfg         (cfg[c]),
                .oe_pin_n    (oe_pin_n),
                .preload_en  (preload_en),
                .preload_val (preload_data[c]),
                .reg_q       (reg_q[c]),
                .pin_out     (io_out[c]),
                .pin_oe      (io_oe[c])
            );
        end
    endgenerate

    // ============================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    AST_UNPROG_TERM: assert property ((fuse[0] == FUSE_ERASED) |-> !term[0])
        else $error("erased term not low");
    AST_SECURE_READ: assert property (secure && rd_en |=> rd_data == '0)
        else $error("secured pattern was read");
    AST_SECURE_STICKY: assert property (secure |=> secure)
        else $error("security bit cleared");
    AST_CFG_WRITE: assert property (cfg_we && int'(cfg_cell) < N_CELL
        |=> cfg[$past(cfg_cell)] == $past(cfg_wdata))
        else $error("configuration not stored");
    AST_PIN_MASK: assert property (!cfg[0][STORE_BIT] |-> !sig[N_DED + N_CELL])
        else $error("pin fed array in registered mode");
    AST_FEEDBACK: assert property (sig[N_DED +: N_CELL] == reg_q)
        else $error("register feedback missing");
    AST_CFG_REFUSED: assert property (
        cfg_we && int'(cfg_cell) >= N_CELL |=> cfg == $past(cfg))
        else $error("out-of-range configuration write landed");
    AST_PROG_WRITE: assert property (
        prog_we && int'(prog_addr) < N_TERM |=> fuse[$past(prog_addr)] == $past(prog_wdata))
        else $error("pattern word not stored");
    AST_READBACK: assert property (
        rd_en && !secure && int'(rd_addr) < N_TERM |=> rd_data == $past(fuse[rd_addr]))
        else $error("open readback wrong");
    AST_SECURE_SET: assert property (secure_set |=> secure)
        else $error("security request not taken");
    AST_PRELOAD_ALL: assert property (preload_en |=> reg_q == $past(preload_data))
        else $error("preload pattern not forced");
    COV_COMB_DRIVE: cover property (cfg[0][STORE_BIT] && io_oe[0]);
    COV_SECURE: cover property (secure && rd_en);

endmodule : pld_output_macrocell

// ==== pld_pkg.sv ====
package pld_pkg;

    // ============================================================
    // Array geometry
    localparam int N_DED       = 12;
    localparam int N_CELL      = 10;
    localparam int N_SIG       = N_DED + 2 * N_CELL;
    localparam int COL_W       = 2 * N_SIG;
    localparam int SUM_TERMS   = 8;
    localparam int TERMS_CELL  = SUM_TERMS + 1;
    localparam int N_TERM      = N_CELL * TERMS_CELL;
    localparam int ADDR_W      = 7;
    localparam int CELL_W      = 4;

    // ============================================================
    // Configuration bit positions and reset values
    localparam int POL_BIT     = 0;
    localparam int STORE_BIT   = 1;
    localparam int OESRC_BIT   = 2;
    localparam logic [2:0]       CFG_RESET   = 3'h0;
    localparam logic [COL_W-1:0] FUSE_ERASED = {COL_W{1'b1}};
    localparam logic             REG_RESET   = 1'b0;

endpackage : pld_pkg

// ==== pld_fuse_store.sv ====
module pld_fuse_store
    import pld_pkg::*;
(
    // Clock and reset
    input  wire logic                                clock,
    input  wire logic                                rstn,
    // Write port
    input  wire logic                                wr_en,
    input  wire logic [pld_pkg::ADDR_W-1:0]          wr_addr,
    input  wire logic [pld_pkg::COL_W-1:0]           wr_data,
    // Read port
    input  wire logic                                rd_en,
    input  wire logic [pld_pkg::ADDR_W-1:0]          rd_addr,
    input  wire logic                                rd_blank,
    output logic      [pld_pkg::COL_W-1:0]           rd_data,
    // Parallel view for the array
    output logic      [pld_pkg::N_TERM-1:0][pld_pkg::COL_W-1:0] fuse
);

    logic [N_TERM-1:0][COL_W-1:0] next_fuse;
    logic [COL_W-1:0]             next_rd_data;

    // ============================================================
    // Next fuse words and readback
    always_comb
    begin
        next_fuse    = fuse;
        next_rd_data = rd_data;
        if (wr_en && (int'(wr_addr) < N_TERM))
        begin
            next_fuse[wr_addr] = wr_data;
        end
        if (rd_en)
        begin
            if (rd_blank || (int'(rd_addr) >= N_TERM))
            begin
                next_rd_data = '0; // Secured pattern reads as zero
            end
            else
            begin
                next_rd_data = fuse[rd_addr];
            end
        end
    end

    // Registers, erased after reset
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            fuse    <= {N_TERM{FUSE_ERASED}};
            rd_data <= '0;
        end
        else
        begin
            fuse    <= next_fuse;
            rd_data <= next_rd_data;
        end
    end

endmodule : pld_fuse_store

// ==== pld_cell.sv ====
module pld_cell
    import pld_pkg::*;
(
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          rstn,
    // Array terms
    input  wire logic [pld_pkg::SUM_TERMS-1:0] sum_terms,
    input  wire logic                          oe_term,
    // Configuration
    input  wire logic [2:0]                    cfg,
    input  wire logic                          oe_pin_n,
    // Preload
    input  wire logic                          preload_en,
    input  wire logic                          preload_val,
    // Results
    output logic                               reg_q,
    output logic                               pin_out,
    output logic                               pin_oe
);

    logic next_q;
    logic sum;
    logic src;

    // ============================================================
    // Sum, register input and output path
    always_comb
    begin
        sum    = |sum_terms;
        next_q = preload_en ? preload_val : sum;
        src    = cfg[STORE_BIT] ? sum : reg_q;
        pin_out = cfg[POL_BIT] ? src : ~src;
        pin_oe  = cfg[OESRC_BIT] ? ~oe_pin_n : oe_term;
    end

    // Register on the common clock, clear at reset
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_q <= REG_RESET;
        end
        else
        begin
            reg_q <= next_q;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    AST_REG_CAPTURE: assert property (!preload_en |=> reg_q == $past(sum))
        else $error("register did not capture sum");
    AST_PRELOAD: assert property (preload_en |=> reg_q == $past(preload_val))
        else $error("preload value not forced");
    AST_COMB_PATH: assert property (cfg[STORE_BIT] |-> pin_out == (cfg[POL_BIT] ~^ sum))
        else $error("combinational output wrong");
    AST_REG_PATH: assert property (!cfg[STORE_BIT] |-> pin_out == (cfg[POL_BIT] ~^ reg_q))
        else $error("registered output wrong");
    AST_OE_TERM: assert property (!cfg[OESRC_BIT] |-> pin_oe == oe_term)
        else $error("term enable not followed");
    AST_OE_PIN: assert property (cfg[OESRC_BIT] |-> pin_oe == !oe_pin_n)
        else $error("pin enable not active low");
    COV_REG_TOGGLE: cover property (!cfg[STORE_BIT] && !reg_q ##1 reg_q);
    COV_PRELOAD: cover property (preload_en && preload_val);

endmodule : pld_cell

// ==== pld_board.sv ====
module pld_board
    import pld_pkg::*;
(
    // Design side of the cell pins
    input  wire logic [pld_pkg::N_CELL-1:0] io_out,
    input  wire logic [pld_pkg::N_CELL-1:0] io_oe,
    // Board drive of the same pins
    input  wire logic [pld_pkg::N_CELL-1:0] drv_val,
    input  wire logic [pld_pkg::N_CELL-1:0] drv_en,
    // Resolved pin level
    output logic      [pld_pkg::N_CELL-1:0] io_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // ============================================================
    // Pin resolution
    // A pin nobody drives sits at ground through its board tie
    always_comb
    begin
        for (int i = 0; i < N_CELL; i++)
        begin
            io_in[i] = io_oe[i] ? io_out[i] : (drv_en[i] ? drv_val[i] : 1'b0);
        end
    end
endmodule : pld_board

// ==== pld_output_macrocell_tb.sv ====
module pld_output_macrocell_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pld_pkg::*;

    typedef struct {int due; int sel; logic [63:0] mask; logic [63:0] exp;} note_s;

    // ============================================================
    // Stimulus and observed signals
    logic                clock        = 1'b0;
    logic                rstn         = 1'b0;
    logic [N_DED-1:0]    ded_in       = '0;
    logic                oe_pin_n     = 1'b1;
    logic [N_CELL-1:0]   io_in;
    logic [N_CELL-1:0]   io_out;
    logic [N_CELL-1:0]   io_oe;
    logic [N_CELL-1:0]   drv_val      = '0;
    logic [N_CELL-1:0]   drv_en       = '0;
    logic                prog_we      = 1'b0;
    logic [ADDR_W-1:0]   prog_addr    = '0;
    logic [COL_W-1:0]    prog_wdata   = '0;
    logic                rd_en        = 1'b0;
    logic [ADDR_W-1:0]   rd_addr      = '0;
    logic [COL_W-1:0]    rd_data;
    logic                cfg_we       = 1'b0;
    logic [CELL_W-1:0]   cfg_cell     = '0;
    logic [2:0]          cfg_wdata    = '0;
    logic                secure_set   = 1'b0;
    logic                secure;
    logic                preload_en   = 1'b0;
    logic [N_CELL-1:0]   preload_data = '0;
    logic [15:0]         rs           = 16'hBF3E;
    int                  nedge        = 0;
    int                  fails        = 0;
    int                  checks_done  = 0;
    note_s               notes[$];
    string               nm[4]        = '{"io_out", "io_oe", "rd_data", "secure"};

    pld_output_macrocell i_dut (.clock(clock), .rstn(rstn), .ded_in(ded_in),
        .oe_pin_n(oe_pin_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .prog_we(prog_we), .prog_addr(prog_addr), .prog_wdata(prog_wdata), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data), .cfg_we(cfg_we), .cfg_cell(cfg_cell),
        .cfg_wdata(cfg_wdata), .secure_set(secure_set), .secure(secure),
        .preload_en(preload_en), .preload_data(preload_data));
    pld_board i_board (.io_out(io_out), .io_oe(io_oe), .drv_val(drv_val), .drv_en(drv_en),
        .io_in(io_in));

    // ============================================================
    // Helpers
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    // Queue a result expected just before the lag-th next edge
    task automatic note(int sel, int lag, logic [63:0] mask, logic [63:0] exp);
        notes.push_back('{nedge + lag, sel, mask, exp});
    endtask : note

    task automatic prog(int a, logic [63:0] w);
        @(posedge clock);
        prog_we    <= 1'b1;
        prog_addr  <= 7'(a);
        prog_wdata <= w;
        @(posedge clock);
        prog_we <= 1'b0;
    endtask : prog

    task automatic cfg(int c, int v);
        @(posedge clock);
        cfg_we    <= 1'b1;
        cfg_cell  <= 4'(c);
        cfg_wdata <= 3'(v);
        @(posedge clock);
        cfg_we <= 1'b0;
    endtask : cfg

    task automatic rd(int a, logic [63:0] exp);
        @(posedge clock);
        rd_en   <= 1'b1;
        rd_addr <= 7'(a);
        note(2, 2, '1, exp);
        @(posedge clock);
        rd_en <= 1'b0;
    endtask : rd

    // ============================================================
    // Clock and watchdog
    initial
    begin
        forever #10 clock = ~clock;
    end

    initial
    begin
        repeat (2000) @(posedge clock);
        fails++;
        test_done();
    end

    // Output monitor takes every due note, oldest first, and compares
    always @(negedge clock)
    begin : monitor
        logic [63:0] seen;
        nedge = nedge + 1;
        while (notes.size() > 0 && notes[0].due <= nedge)
        begin
            case (notes[0].sel)
                0: seen = 64'(io_out);
                1: seen = 64'(io_oe);
                2: seen = rd_data;
                default: seen = 64'(secure);
            endcase
            check(nm[notes[0].sel], seen & notes[0].mask, notes[0].exp);
            void'(notes.pop_front());
        end
    end

    // ============================================================
    // Main sequence
    initial
    begin : main
        logic q0;
        logic v;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        note(0, 1, '1, 64'h3FF);
        note(1, 1, '1, 64'h0);
        rd(0, '1);
        rd(90, 64'h0);
        // Cell 0 follows ded_in[0], cell 1 its feedback, cell 3 pin 2
        prog(0, 64'h1);
        prog(8, 64'h0);
        prog(9, 64'h1000000);
        prog(17, 64'h0);
        prog(27, 64'h1000000000000);
        prog(35, 64'h0);
        // Every configuration of cell 0 with random inputs
        for (int c = 0; c < 8; c++)
        begin
            cfg(0, c);
            repeat (4)
            begin
                @(posedge clock);
                rs = lfsr(rs);
                q0 = ded_in[0];
                ded_in   <= rs[11:0];
                oe_pin_n <= rs[12];
                v = c[1] ? rs[0] : q0;
                note(0, 1, 64'h1, {63'h0, c[0] ? v : ~v});
                note(1, 1, 64'h1, {63'h0, c[2] ? ~rs[12] : 1'b1});
            end
        end
        // Preload all cells, then let the array take over
        for (int i = 0; i < N_CELL; i++) cfg(i, 5);
        cfg(15, 2);
        @(posedge clock);
        rs = lfsr(rs);
        ded_in       <= '0;
        oe_pin_n     <= 1'b0;
        preload_en   <= 1'b1;
        preload_data <= rs[9:0];
        note(1, 1, '1, 64'h3FF);
        note(0, 2, '1, {54'h0, rs[9:0]});
        @(posedge clock);
        preload_en <= 1'b0;
        note(0, 2, '1, {62'h0, rs[0], 1'b0});
        @(posedge clock);
        oe_pin_n <= 1'b1;
        drv_en   <= 10'h004;
        note(1, 1, '1, 64'h0);
        // Pin 2 as input, seen through cell 3
        cfg(3, 3);
        for (int m = 0; m < 2; m++)
        begin
            cfg(2, m ? 4 : 6);
            repeat (3)
            begin
                @(posedge clock);
                rs = lfsr(rs);
                drv_val <= rs[9:0];
                note(1, 1, 64'h4, 64'h0);
                note(0, 1, 64'h8, {60'h0, m ? 1'b0 : rs[2], 3'h0});
            end
        end
        // Security blanks readback
        rd(0, 64'h1);
        @(posedge clock);
        secure_set <= 1'b1;
        note(3, 2, '1, 64'h1);
        @(posedge clock);
        secure_set <= 1'b0;
        rd(0, 64'h0);
        repeat (4) @(posedge clock);
        test_done();
    end
endmodule : pld_output_macrocell_tb
